// ### uab_consts.svh
// offsets, field positions, reset values and timing of the async buffer block
`ifndef UAB_CONSTS_SVH
`define UAB_CONSTS_SVH
`define UAB_A_CTRL 8'h00
`define UAB_A_CMD 8'h04
`define UAB_A_STATUS 8'h08
`define UAB_A_IF 8'h0c
`define UAB_A_IFC 8'h10
`define UAB_A_TXS 8'h14
`define UAB_A_TXP 8'h18
`define UAB_A_TXSX 8'h1c
`define UAB_A_TXPX 8'h20
`define UAB_A_RXS 8'h24
`define UAB_A_RXP 8'h28
`define UAB_A_RXSX 8'h2c
`define UAB_A_RXPX 8'h30
`define UAB_A_RXSP 8'h34
`define UAB_A_RXPP 8'h38
`define UAB_C_NINTH 0
`define UAB_C_LVLSEL 1
`define UAB_C_AUTOMATIC_TRISTATING 2
`define UAB_C_NINEBIT 3
`define UAB_C_SCREP 4
`define UAB_CTRL_RST 5'h00
`define UAB_K_TXON 0
`define UAB_K_TXOFF 1
`define UAB_K_RXON 2
`define UAB_K_RXOFF 3
`define UAB_K_FLTX 4
`define UAB_K_FLRX 5
`define UAB_K_BLKON 6
`define UAB_K_BLKOFF 7
`define UAB_K_UNTRI 8
`define UAB_E_TRI 9
`define UAB_E_UBLK 10
`define UAB_E_RECEIVER_ON_CMD 11
`define UAB_E_DIS 12
`define UAB_E_BRK 13
`define UAB_R_FERR 9
`define UAB_I_TXC 0
`define UAB_I_TXL 1
`define UAB_I_RXDV 2
`define UAB_I_RX_BUFFER_FULL 3
`define UAB_I_TX_OVERFLOW_FLAG 4
`define UAB_I_RX_OVERFLOW_FLAG 5
`define UAB_I_RX_UNDERFLOW_FLAG 6
`define UAB_BIT_NS 1000
`define UAB_CLK_NS 50
`define UAB_BIT_CYC ((`UAB_BIT_NS + `UAB_CLK_NS - 1) / `UAB_CLK_NS)
`endif

// ### uab_ctrl.sv
// async buffer control: tx fifo, per-frame actions, rx buffer, register port
`timescale 1ns/100ps
`include "uab_consts.svh"
// Overview of operation
// [RULE1] two-entry transmit fifo ahead of shift register
// [RULE2] plain writes queue bytes, ninth bit default
// [RULE3] extended writes carry own ninth bit, controls
// [RULE4] fifo overflow raises flag, drops write
// [RULE5] level flag: empty, or below full
// [RULE6] flush empties fifo, shift register, line continues
// [RULE7] break holds stop low, then idle high
// [RULE8] disable transmitter after marked frame
// [RULE9] enable receiver right at frame end
// [RULE10] unblock receiver after marked frame
// [RULE11] release output after frame; auto reads zero
// [RULE12] smartcard repeat defers actions; break forces nack
// [RULE13] start edge begins frame only when idle
// [RULE14] frame waits; overwrite when full, overflow flag
// [RULE15] receiver off discards frame; status shows enable
// [RULE16] valid and full flags; full irq sticky
// [RULE17] shift register holds one frame beyond full
// [RULE18] plain reads low bytes, extended add status
// [RULE19] over-read raises underflow flag
// [RULE20] peeks never remove nor underflow
// [RULE21] receive flush empties buffer, keeps arriving frame
// [RULE22] transmit complete status and sticky flag
// [RULE23] blocked receiver drops frames silently
// [RULE24] receive buffer holds two frames
module uab_ctrl
  import uab_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic RXD,
  input wire logic NACK,
  output logic TXD_O,
  output logic TXD_OE
);
  localparam logic [7:0] BIT_LAST = 8'(`UAB_BIT_CYC - 1);
  localparam logic [7:0] HALF_LAST = 8'(`UAB_BIT_CYC / 2 - 1);

  logic [4:0] ctrl_reg;
  logic tx_on_reg;
  logic rx_on_reg;
  logic blocked_reg;
  logic released_reg;
  logic [13:0] tf_reg [0:1];
  logic [1:0] tf_cnt_reg;
  logic [13:0] tsr_reg;
  logic tsr_full_reg;
  logic [13:0] tl_reg;
  logic [8:0] tx_sh_reg;
  uab_tx_st_t tx_st_reg;
  logic [7:0] tx_cyc_reg;
  logic [3:0] tx_bit_reg;
  logic tx_retry_reg;
  logic txd_reg;
  logic [9:0] rb_reg [0:1];
  logic [1:0] rb_cnt_reg;
  logic [9:0] rsr_reg;
  logic rsr_full_reg;
  uab_rx_st_t rx_st_reg;
  logic [7:0] rx_cyc_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_sh_reg;
  logic [2:0] rxd_sync_reg;
  logic [2:0] nack_sync_reg;
  logic rxd_reg;
  logic rxd_prev_reg;
  logic nack_reg;
  logic [6:0] sticky_reg;
  logic [31:0] rdata_reg;

  logic [8:0] cmd;
  logic [3:0] nlast;
  logic tx_wr1;
  logic tx_wr2;
  logic [13:0] wa;
  logic [13:0] wb;
  logic tf_pop;
  logic [1:0] tf_free;
  logic tx_ovf;
  logic [13:0] q0_next;
  logic [13:0] q1_next;
  logic [1:0] tf_cnt_next;
  logic tx_take;
  logic tx_bit_end;
  logic tx_fail;
  logic tx_done;
  logic [1:0] rq;
  logic rx_uf;
  logic [1:0] pn;
  logic [9:0] b0_next;
  logic [9:0] b1_next;
  logic [1:0] rb_cnt_next;
  logic rsr_mv;
  logic rx_done;
  logic [9:0] rx_frame;
  logic rx_ovf;
  logic txc_st;
  logic txl_st;
  logic [7:0] status;
  logic [6:0] if_view;
  logic [6:0] if_set;
  logic [6:0] if_clr;

  function automatic logic [15:0] fmt(input logic [9:0] e);
    fmt = {1'b0, e[`UAB_R_FERR], 5'h00, e[8:0]};
  endfunction : fmt

  assign cmd = (WR && ADDR == `UAB_A_CMD) ? WDATA[8:0] : 9'h000;
  assign nlast = ctrl_reg[`UAB_C_NINEBIT] ? 4'h8 : 4'h7;

  // transmit write decode
  always_comb begin
    tx_wr1 = 1'b0;
    tx_wr2 = 1'b0;
    wa = {5'h00, ctrl_reg[`UAB_C_NINTH], WDATA[7:0]}; // [RULE2]
    wb = {5'h00, ctrl_reg[`UAB_C_NINTH], WDATA[15:8]}; // [RULE2]
    if (WR) begin
      case (ADDR)
        `UAB_A_TXS: tx_wr1 = 1'b1;
        `UAB_A_TXP: tx_wr2 = 1'b1;
        `UAB_A_TXSX: begin
          tx_wr1 = 1'b1;
          wa = WDATA[13:0]; // [RULE3]
        end
        `UAB_A_TXPX: begin
          tx_wr2 = 1'b1;
          wa = WDATA[13:0]; // [RULE3]
          wb = WDATA[29:16]; // [RULE3]
        end
        default: ;
      endcase
    end
  end

  // a slot freed by this cycle's pop counts as free space
  assign tf_pop = tf_cnt_reg != 2'h0 && !tsr_full_reg;
  assign tf_free = 2'h2 - tf_cnt_reg + {1'b0, tf_pop};
  assign tx_ovf = (tx_wr1 && tf_free == 2'h0) || (tx_wr2 && tf_free != 2'h2); // [RULE4]

  always_comb begin
    q0_next = tf_pop ? tf_reg[1] : tf_reg[0];
    q1_next = tf_reg[1];
    tf_cnt_next = tf_cnt_reg - {1'b0, tf_pop};
    if (tx_wr1 && !tx_ovf) begin
      if (tf_cnt_next == 2'h0) begin
        q0_next = wa;
      end else begin
        q1_next = wa;
      end
      tf_cnt_next = tf_cnt_next + 2'h1;
    end else if (tx_wr2 && !tx_ovf) begin
      q0_next = wa;
      q1_next = wb;
      tf_cnt_next = 2'h2;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tf_reg[0] <= 14'h0000;
      tf_reg[1] <= 14'h0000;
      tf_cnt_reg <= 2'h0;
    end else if (cmd[`UAB_K_FLTX]) begin
      tf_cnt_reg <= 2'h0; // [RULE6]
    end else begin
      tf_reg[0] <= q0_next; // [RULE1]
      tf_reg[1] <= q1_next;
      tf_cnt_reg <= tf_cnt_next;
    end
  end

  // shift register stage; the frame on the line lives in tl_reg
  assign tx_take = tx_st_reg == TX_IDLE && tsr_full_reg && tx_on_reg && !cmd[`UAB_K_FLTX];

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tsr_reg <= 14'h0000;
      tsr_full_reg <= 1'b0;
    end else if (cmd[`UAB_K_FLTX]) begin
      tsr_full_reg <= 1'b0; // [RULE6]
    end else if (tf_pop) begin
      tsr_reg <= tf_reg[0];
      tsr_full_reg <= 1'b1;
    end else if (tx_take) begin
      tsr_full_reg <= 1'b0;
    end
  end

  assign tx_bit_end = tx_cyc_reg == BIT_LAST;
  assign tx_fail = ctrl_reg[`UAB_C_SCREP] && (nack_reg || tl_reg[`UAB_E_BRK]); // [RULE12]
  assign tx_done = tx_st_reg == TX_STOP && tx_bit_end && !tx_fail && !cmd[`UAB_K_TXOFF];

  // transmit line engine; disable aborts, flush does not
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_st_reg <= TX_IDLE;
      tl_reg <= 14'h0000;
      tx_sh_reg <= 9'h000;
      tx_cyc_reg <= 8'h00;
      tx_bit_reg <= 4'h0;
      tx_retry_reg <= 1'b0;
      txd_reg <= 1'b1;
    end else if (cmd[`UAB_K_TXOFF]) begin
      tx_st_reg <= TX_IDLE;
      txd_reg <= 1'b1;
    end else begin
      tx_cyc_reg <= tx_bit_end ? 8'h00 : tx_cyc_reg + 8'h01;
      unique case (tx_st_reg)
        TX_IDLE: begin
          tx_cyc_reg <= 8'h00;
          if (tx_take) begin
            tl_reg <= tsr_reg;
            tx_sh_reg <= tsr_reg[8:0];
            txd_reg <= 1'b0;
            tx_st_reg <= TX_START;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            txd_reg <= tx_sh_reg[0];
            tx_bit_reg <= 4'h0;
            tx_st_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            if (tx_bit_reg == nlast) begin
              txd_reg <= !tl_reg[`UAB_E_BRK]; // [RULE7]
              tx_st_reg <= TX_STOP;
            end else begin
              txd_reg <= tx_sh_reg[1];
              tx_sh_reg <= tx_sh_reg >> 1;
              tx_bit_reg <= tx_bit_reg + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            tx_retry_reg <= tx_fail; // [RULE12]
            tx_sh_reg <= tl_reg[8:0];
            if (tl_reg[`UAB_E_BRK]) begin
              txd_reg <= 1'b1; // [RULE7]
              tx_st_reg <= TX_GAP;
            end else if (tx_fail) begin
              txd_reg <= 1'b0;
              tx_st_reg <= TX_START;
            end else begin
              tx_st_reg <= TX_IDLE;
            end
          end
        end
        TX_GAP: begin
          if (tx_bit_end) begin
            txd_reg <= !tx_retry_reg;
            tx_st_reg <= tx_retry_reg ? TX_START : TX_IDLE;
          end
        end
      endcase
    end
  end

  // control state and the actions a finished frame carries
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= `UAB_CTRL_RST;
      tx_on_reg <= 1'b0;
      rx_on_reg <= 1'b0;
      blocked_reg <= 1'b0;
      released_reg <= 1'b0;
    end else begin
      if (WR && ADDR == `UAB_A_CTRL) begin
        ctrl_reg <= WDATA[4:0];
      end
      if (cmd[`UAB_K_TXON]) begin
        tx_on_reg <= 1'b1;
      end
      if (cmd[`UAB_K_TXOFF] || (tx_done && tl_reg[`UAB_E_DIS])) begin
        tx_on_reg <= 1'b0; // [RULE8]
      end
      // enabled on the stop bit's last cycle, ready for a start at once
      if (cmd[`UAB_K_RXON] || (tx_done && tl_reg[`UAB_E_RECEIVER_ON_CMD])) begin
        rx_on_reg <= 1'b1; // [RULE9]
      end
      if (cmd[`UAB_K_RXOFF]) begin
        rx_on_reg <= 1'b0; // [RULE15]
      end
      if (cmd[`UAB_K_BLKON]) begin
        blocked_reg <= 1'b1;
      end
      if (cmd[`UAB_K_BLKOFF] || (tx_done && tl_reg[`UAB_E_UBLK])) begin
        blocked_reg <= 1'b0; // [RULE10]
      end
      if (cmd[`UAB_K_UNTRI]) begin
        released_reg <= 1'b0;
      end
      if (tx_done && tl_reg[`UAB_E_TRI]) begin
        released_reg <= 1'b1; // [RULE11]
      end
    end
  end

  assign TXD_O = txd_reg;
  assign TXD_OE = !released_reg && !(ctrl_reg[`UAB_C_AUTOMATIC_TRISTATING] && tx_st_reg == TX_IDLE); // [RULE11]

  // pin inputs: a level counts once stages two and three agree
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rxd_sync_reg <= 3'h7;
      nack_sync_reg <= 3'h0;
      rxd_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
      nack_reg <= 1'b0;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[1:0], RXD};
      nack_sync_reg <= {nack_sync_reg[1:0], NACK};
      if (rxd_sync_reg[1] == rxd_sync_reg[2]) begin
        rxd_reg <= rxd_sync_reg[2];
      end
      if (nack_sync_reg[1] == nack_sync_reg[2]) begin
        nack_reg <= nack_sync_reg[2];
      end
      rxd_prev_reg <= rxd_reg;
    end
  end

  // receive line engine; a flush leaves it running
  assign rx_done = rx_st_reg == RX_STOP && rx_cyc_reg == BIT_LAST && !cmd[`UAB_K_RXOFF];
  assign rx_frame[8:0] = ctrl_reg[`UAB_C_NINEBIT] ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};
  assign rx_frame[`UAB_R_FERR] = !rxd_reg;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_st_reg <= RX_IDLE;
      rx_cyc_reg <= 8'h00;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
    end else if (cmd[`UAB_K_RXOFF]) begin
      rx_st_reg <= RX_IDLE; // [RULE15]
    end else begin
      rx_cyc_reg <= rx_cyc_reg + 8'h01;
      unique case (rx_st_reg)
        RX_IDLE: begin
          rx_cyc_reg <= 8'h00;
          if (rx_on_reg && rxd_prev_reg && !rxd_reg) begin
            rx_st_reg <= RX_START; // [RULE13]
          end
        end
        RX_START: begin
          if (rx_cyc_reg == HALF_LAST) begin
            rx_cyc_reg <= 8'h00;
            rx_bit_reg <= 4'h0;
            rx_st_reg <= rxd_reg ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_cyc_reg == BIT_LAST) begin
            rx_cyc_reg <= 8'h00;
            rx_sh_reg <= {rxd_reg, rx_sh_reg[8:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == nlast) begin
              rx_st_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_cyc_reg == BIT_LAST) begin
            rx_st_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // receive buffer: pops first, then the waiting frame moves up
  always_comb begin
    rq = 2'h0;
    if (RD) begin
      case (ADDR)
        `UAB_A_RXS, `UAB_A_RXSX: rq = 2'h1;
        `UAB_A_RXP, `UAB_A_RXPX: rq = 2'h2;
        default: rq = 2'h0; // [RULE20]
      endcase
    end
    rx_uf = rq > rb_cnt_reg; // [RULE19]
    pn = rx_uf ? rb_cnt_reg : rq;
    b0_next = (pn == 2'h1) ? rb_reg[1] : rb_reg[0];
    b1_next = rb_reg[1];
    rb_cnt_next = rb_cnt_reg - pn;
    rsr_mv = rsr_full_reg && rb_cnt_next != 2'h2;
    if (rsr_mv) begin
      if (rb_cnt_next == 2'h0) begin
        b0_next = rsr_reg;
      end else begin
        b1_next = rsr_reg;
      end
      rb_cnt_next = rb_cnt_next + 2'h1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rb_reg[0] <= 10'h000;
      rb_reg[1] <= 10'h000;
      rb_cnt_reg <= 2'h0;
    end else if (cmd[`UAB_K_FLRX]) begin
      rb_cnt_reg <= 2'h0; // [RULE21]
    end else begin
      rb_reg[0] <= b0_next; // [RULE24]
      rb_reg[1] <= b1_next;
      rb_cnt_reg <= rb_cnt_next;
    end
  end

  // a waiting frame still moves up while blocked; only new ones drop
  assign rx_ovf = rx_done && !blocked_reg && rsr_full_reg && !rsr_mv; // [RULE14]

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rsr_reg <= 10'h000;
      rsr_full_reg <= 1'b0;
    end else if (cmd[`UAB_K_FLRX]) begin
      rsr_full_reg <= 1'b0; // [RULE21]
    end else if (rx_done && !blocked_reg) begin
      rsr_reg <= rx_frame; // [RULE14] [RULE17] [RULE23]
      rsr_full_reg <= 1'b1;
    end else if (rsr_mv) begin
      rsr_full_reg <= 1'b0;
    end
  end

  // status and flags
  assign txc_st = tx_on_reg && tf_cnt_reg == 2'h0 && !tsr_full_reg && tx_st_reg == TX_IDLE; // [RULE22]
  assign txl_st = ctrl_reg[`UAB_C_LVLSEL] ? tf_cnt_reg != 2'h2 : tf_cnt_reg == 2'h0; // [RULE5]
  assign status = {released_reg && !ctrl_reg[`UAB_C_AUTOMATIC_TRISTATING], blocked_reg, // [RULE11]
                   rb_cnt_reg == 2'h2, rb_cnt_reg != 2'h0, txl_st, txc_st,
                   rx_on_reg, tx_on_reg}; // [RULE15] [RULE16]

  always_comb begin
    if_set = 7'h00;
    if_set[`UAB_I_TXC] = txc_st; // [RULE22]
    if_set[`UAB_I_RX_BUFFER_FULL] = rb_cnt_reg == 2'h2; // [RULE16]
    if_set[`UAB_I_TX_OVERFLOW_FLAG] = tx_ovf; // [RULE4]
    if_set[`UAB_I_RX_OVERFLOW_FLAG] = rx_ovf; // [RULE14]
    if_set[`UAB_I_RX_UNDERFLOW_FLAG] = rx_uf; // [RULE19]
    if_clr = (WR && ADDR == `UAB_A_IFC) ? WDATA[6:0] : 7'h00;
    if_view = sticky_reg;
    if_view[`UAB_I_TXL] = txl_st; // [RULE5]
    if_view[`UAB_I_RXDV] = rb_cnt_reg != 2'h0; // [RULE16]
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sticky_reg <= 7'h00;
    end else begin
      sticky_reg <= (sticky_reg & ~if_clr) | if_set;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        `UAB_A_CTRL: rdata_reg <= {27'h0, ctrl_reg};
        `UAB_A_STATUS: rdata_reg <= {24'h0, status};
        `UAB_A_IF: rdata_reg <= {25'h0, if_view};
        `UAB_A_RXS: rdata_reg <= {24'h0, rb_reg[0][7:0]}; // [RULE18]
        `UAB_A_RXP: rdata_reg <= {16'h0, rb_reg[1][7:0], rb_reg[0][7:0]}; // [RULE18]
        `UAB_A_RXSX, `UAB_A_RXSP: rdata_reg <= {16'h0, fmt(rb_reg[0])}; // [RULE18] [RULE20]
        `UAB_A_RXPX, `UAB_A_RXPP: rdata_reg <= {fmt(rb_reg[1]), fmt(rb_reg[0])}; // [RULE20]
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign RDATA = rdata_reg;
endmodule : uab_ctrl

// ### uab_ctrl_properties.sv
// port assertions for the async buffer control block
`timescale 1ns/100ps
module uab_ctrl_chk (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic TXD_O,
  input wire logic TXD_OE
);
  logic [7:0] low_run_reg;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  // saturates so a stuck line cannot wrap back into the legal range
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      low_run_reg <= 8'h00;
    end else if (TXD_O) begin
      low_run_reg <= 8'h00;
    end else if (low_run_reg != 8'hff) begin
      low_run_reg <= low_run_reg + 8'h01;
    end
  end
  rd_quiet_a:
    assert property (!$past(RD) |-> RDATA == 32'h0) else $error("read data outside answer");
  low_drive_a:
    assert property (!TXD_O |-> TXD_OE) else $error("line low while released");
  release_high_a:
    assert property ($fell(TXD_OE) |-> TXD_O) else $error("released in mid frame");
  break_len_a:
    assert property (low_run_reg <= 8'hdc) else $error("line low beyond one frame");
  high_gap_a:
    assert property ($rose(TXD_O) |-> TXD_O [*8]) else $error("high period too short");
  if_width_a:
    assert property ($past(RD) && $past(ADDR) == 8'h0c |-> RDATA[31:7] == 25'h0)
    else $error("flag read has stray bits");
  stat_width_a:
    assert property ($past(RD) && $past(ADDR) == 8'h08 |-> RDATA[31:8] == 24'h0)
    else $error("status read has stray bits");
  byte_width_a:
    assert property ($past(RD) && $past(ADDR) == 8'h24 |-> RDATA[31:8] == 24'h0)
    else $error("plain read wider than a byte");
  pair_width_a:
    assert property ($past(RD) && $past(ADDR) == 8'h28 |-> RDATA[31:16] == 16'h0)
    else $error("plain pair read wider than two bytes");
endmodule : uab_ctrl_chk
bind uab_ctrl uab_ctrl_chk u_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .RD(RD),
  .RDATA(RDATA), .TXD_O(TXD_O), .TXD_OE(TXD_OE));

// ### uab_ctrl_tb_top.sv
// self-checking bench for the async buffer control block
`timescale 1ns/100ps
module uab_ctrl_tb_top;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic NACK = 1'b0;
  logic nine = 1'b0;
  logic [31:0] RDATA;
  logic RXD;
  logic TXD_O;
  logic TXD_OE;
  logic line;
  logic [31:0] v;
  int error_cnt = 0;
  int checked = 0;
  always #25 SYS_CLK = ~SYS_CLK;
  // a released line floats high through the pull-up
  assign line = TXD_OE ? TXD_O : 1'b1;
  uab_ctrl u_dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RXD(RXD), .NACK(NACK), .TXD_O(TXD_O), .TXD_OE(TXD_OE));
  uab_peer u_peer (.clk(SYS_CLK), .line(line), .nine(nine), .rxd(RXD));
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1;
    v = RDATA;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(v & m, e);
  endtask : rc
  task automatic cmd(input logic [31:0] d);
    wr(8'h04, d);
  endtask : cmd
  task automatic wq(input int n);
    for (int i = 0; i < 2000 && u_peer.q.size() < n; i++) begin
      @(posedge SYS_CLK);
    end
    if (u_peer.q.size() < n) begin
      error_cnt++;
      $display("Error at %0t: no frame on the line", $time);
      finish_test();
    end
  endtask : wq
  task automatic qc(input int i, input logic [9:0] e);
    chk(32'(u_peer.q[i]), 32'(e));
  endtask : qc
  // the extra cycles cover the receive synchroniser delay
  task automatic pkt(input logic [8:0] d, input logic s);
    u_peer.send(d, s);
    cyc(8);
  endtask : pkt
  task automatic t_tx();
    logic [9:0] e [6] = '{10'h333, 10'h233, 10'h355, 10'h2aa, 10'h311, 10'h344};
    rc(8'h08, 32'hff, 32'h08);
    wr(8'h18, 32'h0000a55a);
    wr(8'h18, 32'h00003c3c);
    rc(8'h0c, 32'h10, 32'h10);
    rc(8'h08, 32'h08, 32'h0);
    wr(8'h10, 32'h10);
    cmd(32'h1);
    wq(2);
    cyc(300);
    chk(32'(u_peer.q.size()), 32'h2);
    qc(0, 10'h25a);
    qc(1, 10'h2a5);
    rc(8'h08, 32'h0c, 32'h0c);
    rc(8'h0c, 32'h13, 32'h03);
    u_peer.q.delete();
    nine = 1'b1;
    wr(8'h00, 32'h9);
    wr(8'h14, 32'h33);
    wr(8'h1c, 32'h033);
    wq(2);
    wr(8'h20, 32'h00aa0155);
    wq(4);
    wr(8'h18, 32'h00004411);
    wq(6);
    for (int i = 0; i < 6; i++) begin
      qc(i, e[i]);
    end
    wr(8'h00, 32'h0);
    nine = 1'b0;
    $display("transmit queue done");
  endtask : t_tx
  task automatic t_act();
    u_peer.q.delete();
    wr(8'h1c, 32'h200f);
    wr(8'h14, 32'h81);
    wq(2);
    qc(0, 10'h00f);
    qc(1, 10'h281);
    u_peer.q.delete();
    wr(8'h20, 32'h00221011);
    wq(1);
    cyc(400);
    chk(32'(u_peer.q.size()), 32'h1);
    rc(8'h08, 32'h1, 32'h0);
    cmd(32'h10);
    cmd(32'h1);
    u_peer.q.delete();
    wr(8'h14, 32'h11);
    cyc(40);
    wr(8'h14, 32'h22);
    wr(8'h14, 32'h33);
    cmd(32'h10);
    wq(1);
    cyc(300);
    chk(32'(u_peer.q.size()), 32'h1);
    qc(0, 10'h211);
    $display("frame actions done");
  endtask : t_act
  task automatic t_link();
    u_peer.q.delete();
    wr(8'h1c, 32'h0805);
    wq(1);
    cyc(9);
    pkt(9'h0c3, 1'b1);
    rc(8'h2c, 32'h41ff, 32'h00c3);
    cmd(32'h40);
    pkt(9'h044, 1'b1);
    rc(8'h08, 32'h52, 32'h42);
    u_peer.q.delete();
    wr(8'h1c, 32'h0466);
    wq(1);
    cyc(20);
    rc(8'h08, 32'h40, 32'h0);
    pkt(9'h045, 1'b1);
    rc(8'h24, 32'hffffffff, 32'h45);
    wr(8'h1c, 32'h0277);
    wq(2);
    cyc(20);
    rc(8'h08, 32'h80, 32'h80);
    chk(32'(TXD_OE), 32'h0);
    cmd(32'h100);
    // the clear lands on the edge the command returns at
    cyc(1);
    chk(32'(TXD_OE), 32'h1);
    wr(8'h00, 32'h4);
    wr(8'h1c, 32'h0278);
    wq(3);
    cyc(20);
    rc(8'h08, 32'h80, 32'h0);
    chk(32'(TXD_OE), 32'h0);
    // a release left standing would hide the next frame from the peer
    cmd(32'h100);
    NACK <= 1'b1;
    wr(8'h00, 32'h10);
    wr(8'h1c, 32'h1099);
    wq(4);
    cyc(30);
    rc(8'h08, 32'h1, 32'h1);
    cyc(1);
    NACK <= 1'b0;
    wq(5);
    cyc(30);
    rc(8'h08, 32'h1, 32'h0);
    qc(4, 10'h299);
    wr(8'h00, 32'h0);
    $display("link control done");
  endtask : t_link
  task automatic t_rx();
    rd(8'h38);
    rc(8'h0c, 32'h40, 32'h0);
    pkt(9'h001, 1'b1);
    rc(8'h08, 32'h30, 32'h10);
    rc(8'h34, 32'h41ff, 32'h0001);
    pkt(9'h002, 1'b0);
    rc(8'h08, 32'h30, 32'h30);
    rc(8'h38, 32'h41ff41ff, 32'h40020001);
    pkt(9'h003, 1'b1);
    rc(8'h0c, 32'h2c, 32'h0c);
    pkt(9'h004, 1'b1);
    rc(8'h0c, 32'h20, 32'h20);
    rc(8'h28, 32'hffffffff, 32'h0201);
    rc(8'h2c, 32'h41ff, 32'h0004);
    rc(8'h0c, 32'h4c, 32'h08);
    wr(8'h10, 32'h08);
    rc(8'h0c, 32'h0c, 32'h0);
    rd(8'h24);
    rc(8'h0c, 32'h40, 32'h40);
    pkt(9'h005, 1'b1);
    pkt(9'h006, 1'b1);
    fork
      u_peer.send(9'h007, 1'b1);
      begin
        cyc(100);
        cmd(32'h20);
      end
    join
    cyc(8);
    rc(8'h2c, 32'h41ff, 32'h0007);
    fork
      u_peer.send(9'h008, 1'b1);
      begin
        cyc(100);
        cmd(32'h8);
      end
    join
    cyc(8);
    rc(8'h08, 32'h12, 32'h0);
    $display("receive buffer done");
  endtask : t_rx
  // level select, idle flag clearing, receiver command, extended pair read, pair over-read
  task automatic t_more();
    wr(8'h00, 32'h2);
    wr(8'h14, 32'h55);
    wr(8'h14, 32'h66);
    rc(8'h08, 32'h0d, 32'h08);
    wr(8'h14, 32'h77);
    rc(8'h08, 32'h08, 32'h0);
    rc(8'h0c, 32'h02, 32'h0);
    cmd(32'h10);
    cmd(32'h1);
    rc(8'h08, 32'h0c, 32'h0c);
    wr(8'h00, 32'h0);
    u_peer.q.delete();
    wr(8'h14, 32'h5a);
    rc(8'h08, 32'h04, 32'h0);
    wq(1);
    qc(0, 10'h25a);
    cmd(32'h4);
    rc(8'h08, 32'h02, 32'h02);
    pkt(9'h011, 1'b1);
    pkt(9'h012, 1'b1);
    rc(8'h30, 32'h41ff41ff, 32'h00120011);
    wr(8'h10, 32'h40);
    pkt(9'h013, 1'b1);
    rd(8'h28);
    rc(8'h0c, 32'h44, 32'h40);
    $display("extra modes done");
  endtask : t_more
  initial begin
    cyc(16);
    RESETN <= 1'b1;
    t_tx();
    t_act();
    t_link();
    t_rx();
    t_more();
    finish_test();
  end
endmodule : uab_ctrl_tb_top

// ### uab_peer.sv
// remote serial peer: sends frames on the receive pin, catches frames off the line
`timescale 1ns/100ps
module uab_peer (
  input wire logic clk,
  input wire logic line,
  input wire logic nine,
  output logic rxd
);
  logic [9:0] q[$];
  logic [9:0] f;
  initial rxd = 1'b1;
  // mid-bit sampling tolerates the few idle cycles between frames; bit 9 holds the stop level
  always begin
    @(negedge line);
    f = 10'h000;
    repeat (10) @(posedge clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (20) @(posedge clk);
      f[i] = line;
    end
    repeat (20) @(posedge clk);
    f[9] = line;
    q.push_back(f);
  end
  task automatic send(input logic [8:0] d, input logic stp);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (20) @(posedge clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      rxd <= d[i];
      repeat (20) @(posedge clk);
    end
    rxd <= stp;
    repeat (20) @(posedge clk);
    rxd <= 1'b1;
  endtask : send
endmodule : uab_peer

// ### uab_pkg.sv
// state types for the async buffer block
package uab_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_GAP} uab_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uab_rx_st_t;
endpackage : uab_pkg
